// *** rtl/ohc_buf2.sv ***
`timescale 1ns/1ps

// Two-entry skid buffer; output word sits directly in a flip-flop
module ohc_buf2 #(
	parameter int W = 21
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic flush,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);

	logic ov_r, ov_nxt, sv_r, sv_nxt;
	logic [W-1:0] od_r, od_nxt, sd_r, sd_nxt;

	// Skid entry full means the filler must wait
	assign in_ready = !sv_r;
	assign out_valid = ov_r;
	assign out_data = od_r;

	// Next state of both entries
	always_comb begin
		ov_nxt = ov_r;
		od_nxt = od_r;
		sv_nxt = sv_r;
		sd_nxt = sd_r;
		if (!ov_r || out_ready) begin
			if (sv_r) begin
				ov_nxt = 1'b1;
				od_nxt = sd_r;
				sv_nxt = 1'b0;
			end else begin
				ov_nxt = in_valid;
				od_nxt = in_data;
			end
		end else if (in_valid && !sv_r) begin
			sv_nxt = 1'b1;
			sd_nxt = in_data;
		end
		if (flush) begin
			ov_nxt = 1'b0;
			sv_nxt = 1'b0;
		end
	end

	// Registers, frozen while the enable is low
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ov_r <= 1'b0;
			sv_r <= 1'b0;
			od_r <= '0;
			sd_r <= '0;
		end else if (clk_en) begin
			ov_r <= ov_nxt;
			sv_r <= sv_nxt;
			od_r <= od_nxt;
			sd_r <= sd_nxt;
		end
	end

endmodule // ohc_buf2

// *** rtl/ohc_cmd_port.sv ***
// Notes on behaviour
// [RQ1] Select line high routes a byte to display data, low to the decoder.
// [RQ2] Strap code zero picks 8080 parallel; others pick 6800, serial or two-wire.
// [RQ3] 8080 mode: byte on write strobe rising edge, chip select low.
// [RQ4] Serial mode: data on line 1, clock on line 0, eight bits a byte.
// [RQ5] Two-wire mode: clock line 0, data in line 1, out line 2, select sets address bit.
// [RQ6] Host sends commands and parameters as writes only.
// [RQ7] Opcode 15h sets six-bit column start and end; reset 00h and 3Fh.
// [RQ8] Opcode 75h sets seven-bit row start and end; reset 00h and 7Fh.
// [RQ9] Opcode 81h sets contrast 0 to 255; resets to 7Fh.
// [RQ10] Opcodes 84h to 86h are accepted and change nothing.
// [RQ11] Re-map bit 0 reverses column order into display RAM.
// [RQ12] Re-map bit 1 swaps the two pixel nibbles of each byte.
// [RQ13] Re-map bit 2 clear advances columns first, set advances rows first.
// [RQ14] Re-map bit 4 reverses common scan; bits 3, 5, 7 stay zero.
// [RQ15] Re-map bit 6 enables odd/even common split.
// [RQ16] Parameters follow their opcode at once, select line low, in order.
// [RQ17] Each data byte advances the pointer inside the window, wrapping to start; a byte dropped while link_busy and the skid entry is full does not.
// [RQ18] Hardware reset pin low restores all settings and drops partial commands.
`timescale 1ns/1ps
`include "ohc_params.svh"

module ohc_cmd_port (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic [1:0] link_strap,
	input wire logic hard_reset_n,
	input wire logic cs_n,
	input wire logic dc_sel,
	input wire logic wr_n,
	input wire logic rd_n,
	input wire logic [7:0] data_in,
	output logic sda_out,
	output logic sda_oe,
	output logic [5:0] col_start,
	output logic [5:0] col_end,
	output logic [6:0] row_start,
	output logic [6:0] row_end,
	output logic [7:0] contrast,
	output logic [7:0] remap,
	output logic link_busy,
	output logic pixel_valid,
	input wire logic pixel_ready,
	output logic [7:0] pixel_data,
	output logic [5:0] pixel_col,
	output logic [6:0] pixel_row
);

	////////////////////////////////////////////////////////////////////
	// Pin synchronisers

	logic [`OHC_PIN_W-1:0] pin_raw, s1_r, s2_r;
	assign pin_raw = {link_strap, hard_reset_n, cs_n, dc_sel, wr_n, rd_n, data_in};

	// Two flops on every pin; only s2 feeds logic
	genvar gi;
	generate
		for (gi = 0; gi < `OHC_PIN_W; gi++) begin : g_sync
			always_ff @(posedge clk_sys or negedge rst_n) begin
				if (!rst_n) begin
					s1_r[gi] <= 1'b1;
					s2_r[gi] <= 1'b1;
				end else if (clk_en) begin
					s1_r[gi] <= pin_raw[gi];
					s2_r[gi] <= s1_r[gi];
				end
			end
		end
	endgenerate

	logic hard_rst, p_cs_n, p_dc, p_wr, p_rd, p_d0, p_d1;
	assign hard_rst = !s2_r[`OHC_PIN_HRST];
	assign p_cs_n = s2_r[`OHC_PIN_CS];
	assign p_dc = s2_r[`OHC_PIN_DC];
	assign p_wr = s2_r[`OHC_PIN_WR];
	assign p_rd = s2_r[`OHC_PIN_RD];
	assign p_d0 = s2_r[0];
	assign p_d1 = s2_r[1];

	////////////////////////////////////////////////////////////////////
	// Link receiver: turns any of the four links into byte strobes

	ohc_pkg::ohc_link_t mode_r, mode_nxt;
	ohc_pkg::ohc_i2c_st_t ist_r, ist_nxt;
	logic [1:0] mode_ok_r, mode_ok_nxt;
	logic wr_q_r, wr_q_nxt, rd_q_r, rd_q_nxt, d0_q_r, d0_q_nxt, d1_q_r, d1_q_nxt;
	logic [7:0] lat_r, lat_nxt, sh_r, sh_nxt, byte_r, byte_nxt;
	logic ldc_r, ldc_nxt, bdc_r, bdc_nxt, stb_r, stb_nxt;
	logic [3:0] cnt_r, cnt_nxt;
	logic co_r, co_nxt, idc_r, idc_nxt, oe_r, oe_nxt;
	logic [7:0] sh_in;
	logic scl_rise, scl_fall, i2c_start, i2c_stop;

	assign sh_in = {sh_r[6:0], p_d1};
	assign scl_rise = p_d0 && !d0_q_r;
	assign scl_fall = !p_d0 && d0_q_r;
	assign i2c_start = p_d0 && d0_q_r && d1_q_r && !p_d1;
	assign i2c_stop = p_d0 && d0_q_r && !d1_q_r && p_d1;

	// Strobe data is latched while the strobe is active, since its short
	// hold time would otherwise be gone once the edge clears the synchroniser
	always_comb begin
		mode_nxt = mode_r;
		mode_ok_nxt = mode_ok_r;
		wr_q_nxt = p_wr;
		rd_q_nxt = p_rd;
		d0_q_nxt = p_d0;
		d1_q_nxt = p_d1;
		lat_nxt = lat_r;
		ldc_nxt = ldc_r;
		sh_nxt = sh_r;
		cnt_nxt = cnt_r;
		byte_nxt = byte_r;
		bdc_nxt = bdc_r;
		stb_nxt = 1'b0;
		ist_nxt = ist_r;
		co_nxt = co_r;
		idc_nxt = idc_r;
		oe_nxt = oe_r;
		// Straps re-read until the synchronisers carry them, then frozen;
		// earlier edges would still see the synchroniser reset value
		if (mode_ok_r != `OHC_STRAP_SETTLE) begin
			mode_ok_nxt = mode_ok_r + 2'h1;
			case (s2_r[`OHC_PIN_W-1:`OHC_PIN_MODE_LO])
				2'b01: mode_nxt = ohc_pkg::OHC_L6800;
				2'b10: mode_nxt = ohc_pkg::OHC_LSPI;
				2'b11: mode_nxt = ohc_pkg::OHC_LI2C;
				default: mode_nxt = ohc_pkg::OHC_L8080; // [RQ2]
			endcase
		end
		case (mode_r)
			ohc_pkg::OHC_L8080: begin
				if (!p_cs_n && !p_wr) begin
					lat_nxt = s2_r[7:0];
					ldc_nxt = p_dc;
				end
				if (!p_cs_n && p_wr && !wr_q_r && p_rd) begin // [RQ3]
					stb_nxt = 1'b1;
					byte_nxt = lat_r;
					bdc_nxt = ldc_r;
				end
			end
			ohc_pkg::OHC_L6800: begin
				// Enable on the read pin, direction on the write pin
				if (!p_cs_n && p_rd) begin
					lat_nxt = s2_r[7:0];
					ldc_nxt = p_dc;
				end
				if (!p_cs_n && !p_rd && rd_q_r && !p_wr) begin // [RQ6]
					stb_nxt = 1'b1;
					byte_nxt = lat_r;
					bdc_nxt = ldc_r;
				end
			end
			ohc_pkg::OHC_LSPI: begin
				if (p_cs_n) begin
					cnt_nxt = 4'h0;
				end else if (scl_rise) begin // [RQ4]
					sh_nxt = sh_in;
					cnt_nxt = cnt_r + 4'h1;
					if (cnt_r == `OHC_BIT_LAST) begin
						stb_nxt = 1'b1;
						byte_nxt = sh_in;
						bdc_nxt = p_dc;
						cnt_nxt = 4'h0;
					end
				end
			end
			default: begin
				if (i2c_start) begin
					ist_nxt = ohc_pkg::OHC_I_ADDR;
					cnt_nxt = 4'h0;
					oe_nxt = 1'b0;
				end else if (i2c_stop) begin
					ist_nxt = ohc_pkg::OHC_I_IDLE;
					oe_nxt = 1'b0;
				end else if (ist_r != ohc_pkg::OHC_I_IDLE) begin
					if (scl_rise && cnt_r < `OHC_BIT_ACK) begin
						sh_nxt = sh_in;
						cnt_nxt = cnt_r + 4'h1;
					end else if (scl_fall && cnt_r == `OHC_BIT_ACK) begin
						// Acknowledge is driven for the ninth clock
						oe_nxt = 1'b1;
						cnt_nxt = `OHC_BIT_REL;
						case (ist_r)
							ohc_pkg::OHC_I_ADDR: begin
								// Select pin is the low address bit here
								if (sh_r[7:1] == {`OHC_I2C_ADDR_HI, p_dc} && !sh_r[0]) begin // [RQ5]
									ist_nxt = ohc_pkg::OHC_I_CTL;
								end else begin
									ist_nxt = ohc_pkg::OHC_I_IDLE;
									oe_nxt = 1'b0;
								end
							end
							ohc_pkg::OHC_I_CTL: begin
								co_nxt = sh_r[7];
								idc_nxt = sh_r[6];
								ist_nxt = ohc_pkg::OHC_I_PAY;
							end
							default: begin
								stb_nxt = 1'b1;
								byte_nxt = sh_r;
								bdc_nxt = idc_r;
								ist_nxt = co_r ? ohc_pkg::OHC_I_CTL : ohc_pkg::OHC_I_PAY;
							end
						endcase
					end else if (scl_fall && cnt_r == `OHC_BIT_REL) begin
						oe_nxt = 1'b0;
						cnt_nxt = 4'h0;
					end
				end
			end
		endcase
		if (hard_rst) begin // [RQ18]
			stb_nxt = 1'b0;
			cnt_nxt = 4'h0;
			ist_nxt = ohc_pkg::OHC_I_IDLE;
			oe_nxt = 1'b0;
		end
	end

	// Link registers
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			mode_r <= ohc_pkg::OHC_L8080;
			mode_ok_r <= 2'h0;
			wr_q_r <= 1'b1;
			rd_q_r <= 1'b1;
			d0_q_r <= 1'b1;
			d1_q_r <= 1'b1;
			lat_r <= 8'h00;
			ldc_r <= 1'b0;
			sh_r <= 8'h00;
			cnt_r <= 4'h0;
			byte_r <= 8'h00;
			bdc_r <= 1'b0;
			stb_r <= 1'b0;
			ist_r <= ohc_pkg::OHC_I_IDLE;
			co_r <= 1'b0;
			idc_r <= 1'b0;
			oe_r <= 1'b0;
		end else if (clk_en) begin
			mode_r <= mode_nxt;
			mode_ok_r <= mode_ok_nxt;
			wr_q_r <= wr_q_nxt;
			rd_q_r <= rd_q_nxt;
			d0_q_r <= d0_q_nxt;
			d1_q_r <= d1_q_nxt;
			lat_r <= lat_nxt;
			ldc_r <= ldc_nxt;
			sh_r <= sh_nxt;
			cnt_r <= cnt_nxt;
			byte_r <= byte_nxt;
			bdc_r <= bdc_nxt;
			stb_r <= stb_nxt;
			ist_r <= ist_nxt;
			co_r <= co_nxt;
			idc_r <= idc_nxt;
			oe_r <= oe_nxt;
		end
	end

	assign sda_oe = oe_r;
	assign sda_out = 1'b0; // Open drain: only ever pulls low

	////////////////////////////////////////////////////////////////////
	// Command decoder and display RAM pointer

	ohc_pkg::ohc_cmd_st_t st_r, st_nxt;
	logic [7:0] op_r, op_nxt, con_r, con_nxt, rm_r, rm_nxt;
	logic [5:0] cs_r, cs_nxt, ce_r, ce_nxt, pc_r, pc_nxt;
	logic [6:0] rs_r, rs_nxt, re_r, re_nxt, pr_r, pr_nxt, ts_r, ts_nxt;
	logic pv_r, pv_nxt;
	logic [`OHC_PIX_W-1:0] pd_r, pd_nxt;
	logic buf_ready;

	// Opcodes that take parameter bytes
	function automatic logic takes_param(input logic [7:0] op);
		takes_param = (op == `OHC_OP_COL) || (op == `OHC_OP_ROW) ||
			(op == `OHC_OP_CONTRAST) || (op == `OHC_OP_REMAP);
	endfunction

	always_comb begin
		st_nxt = st_r;
		op_nxt = op_r;
		con_nxt = con_r;
		rm_nxt = rm_r;
		cs_nxt = cs_r;
		ce_nxt = ce_r;
		rs_nxt = rs_r;
		re_nxt = re_r;
		pc_nxt = pc_r;
		pr_nxt = pr_r;
		ts_nxt = ts_r;
		pv_nxt = pv_r;
		pd_nxt = pd_r;
		if (pv_r && buf_ready) begin
			pv_nxt = 1'b0;
		end
		if (stb_r && !bdc_r) begin // [RQ1]
			case (st_r)
				ohc_pkg::OHC_S_P1: begin // [RQ16]
					st_nxt = ohc_pkg::OHC_S_P2;
					case (op_r)
						// Start held aside so a cut command leaves the window whole
						`OHC_OP_COL: ts_nxt = {1'b0, byte_r[5:0]}; // [RQ7]
						`OHC_OP_ROW: ts_nxt = byte_r[6:0]; // [RQ8]
						`OHC_OP_CONTRAST: begin
							con_nxt = byte_r; // [RQ9]
							st_nxt = ohc_pkg::OHC_S_OP;
						end
						default: begin
							rm_nxt = byte_r & `OHC_REMAP_MASK; // [RQ14] [RQ15]
							st_nxt = ohc_pkg::OHC_S_OP;
						end
					endcase
				end
				ohc_pkg::OHC_S_P2: begin
					st_nxt = ohc_pkg::OHC_S_OP;
					if (op_r == `OHC_OP_COL) begin
						cs_nxt = ts_r[5:0];
						ce_nxt = byte_r[5:0]; // [RQ7]
						pc_nxt = ts_r[5:0];
					end else begin
						rs_nxt = ts_r;
						re_nxt = byte_r[6:0]; // [RQ8]
						pr_nxt = ts_r;
					end
				end
				default: begin
					// Reserved and unknown opcodes fall through untouched
					op_nxt = byte_r;
					if (takes_param(byte_r)) begin // [RQ10]
						st_nxt = ohc_pkg::OHC_S_P1;
					end
				end
			endcase
		end else if (stb_r && !(pv_r && !buf_ready)) begin
			// A data byte abandons any half-received command
			st_nxt = ohc_pkg::OHC_S_OP;
			pv_nxt = 1'b1;
			pd_nxt[20:13] = rm_r[`OHC_RM_NIB] ? {byte_r[3:0], byte_r[7:4]} : byte_r; // [RQ12]
			pd_nxt[12:7] = rm_r[`OHC_RM_COL] ? `OHC_COL_MAX - pc_r : pc_r; // [RQ11]
			pd_nxt[6:0] = pr_r;
			if (!rm_r[`OHC_RM_VERT]) begin // [RQ13]
				pc_nxt = (pc_r == ce_r) ? cs_r : pc_r + 6'h01; // [RQ17]
				if (pc_r == ce_r) begin
					pr_nxt = (pr_r == re_r) ? rs_r : pr_r + 7'h01;
				end
			end else begin
				pr_nxt = (pr_r == re_r) ? rs_r : pr_r + 7'h01; // [RQ17]
				if (pr_r == re_r) begin
					pc_nxt = (pc_r == ce_r) ? cs_r : pc_r + 6'h01;
				end
			end
		end
		if (hard_rst) begin // [RQ18]
			st_nxt = ohc_pkg::OHC_S_OP;
			con_nxt = `OHC_CONTRAST_RST;
			rm_nxt = `OHC_REMAP_RST;
			cs_nxt = `OHC_COL_START_RST;
			ce_nxt = `OHC_COL_END_RST;
			rs_nxt = `OHC_ROW_START_RST;
			re_nxt = `OHC_ROW_END_RST;
			pc_nxt = `OHC_COL_START_RST;
			pr_nxt = `OHC_ROW_START_RST;
			pv_nxt = 1'b0;
		end
	end

	// Decoder registers
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= ohc_pkg::OHC_S_OP;
			op_r <= 8'h00;
			con_r <= `OHC_CONTRAST_RST;
			rm_r <= `OHC_REMAP_RST;
			cs_r <= `OHC_COL_START_RST;
			ce_r <= `OHC_COL_END_RST;
			rs_r <= `OHC_ROW_START_RST;
			re_r <= `OHC_ROW_END_RST;
			pc_r <= `OHC_COL_START_RST;
			pr_r <= `OHC_ROW_START_RST;
			ts_r <= 7'h00;
			pv_r <= 1'b0;
			pd_r <= '0;
		end else if (clk_en) begin
			st_r <= st_nxt;
			op_r <= op_nxt;
			con_r <= con_nxt;
			rm_r <= rm_nxt;
			cs_r <= cs_nxt;
			ce_r <= ce_nxt;
			rs_r <= rs_nxt;
			re_r <= re_nxt;
			pc_r <= pc_nxt;
			pr_r <= pr_nxt;
			ts_r <= ts_nxt;
			pv_r <= pv_nxt;
			pd_r <= pd_nxt;
		end
	end

	assign col_start = cs_r;
	assign col_end = ce_r;
	assign row_start = rs_r;
	assign row_end = re_r;
	assign contrast = con_r;
	assign remap = rm_r;
	// Staging word still waiting: a further data byte now would be dropped if the skid entry is also full
	assign link_busy = pv_r;

	////////////////////////////////////////////////////////////////////
	// Output buffer toward display RAM

	logic [`OHC_PIX_W-1:0] buf_out;

	ohc_buf2 #(.W(`OHC_PIX_W)) u_buf (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.flush(hard_rst),
		.in_valid(pv_r),
		.in_ready(buf_ready),
		.in_data(pd_r),
		.out_valid(pixel_valid),
		.out_ready(pixel_ready),
		.out_data(buf_out)
	);

	assign pixel_data = buf_out[20:13];
	assign pixel_col = buf_out[12:7];
	assign pixel_row = buf_out[6:0];

endmodule // ohc_cmd_port

// *** rtl/ohc_params.svh ***
`ifndef OHC_PARAMS_SVH
`define OHC_PARAMS_SVH

// Opcodes decoded by the command port
`define OHC_OP_COL 8'h15
`define OHC_OP_ROW 8'h75
`define OHC_OP_CONTRAST 8'h81
`define OHC_OP_RSV_LO 8'h84
`define OHC_OP_RSV_HI 8'h86
`define OHC_OP_REMAP 8'hA0

// Reset values of decoded settings, then the last column used for reversed order
`define OHC_COL_START_RST 6'h00
`define OHC_COL_END_RST 6'h3F
`define OHC_ROW_START_RST 7'h00
`define OHC_ROW_END_RST 7'h7F
`define OHC_CONTRAST_RST 8'h7F
`define OHC_REMAP_RST 8'h00
`define OHC_COL_MAX 6'h3F

// Writable re-map bits; 3, 5 and 7 stay zero
`define OHC_REMAP_MASK 8'h57
`define OHC_RM_COL 0
`define OHC_RM_NIB 1
`define OHC_RM_VERT 2
`define OHC_RM_COM 4
`define OHC_RM_SPLIT 6

// Positions in the synchronised pin vector
`define OHC_PIN_RD 8
`define OHC_PIN_WR 9
`define OHC_PIN_DC 10
`define OHC_PIN_CS 11
`define OHC_PIN_HRST 12
`define OHC_PIN_MODE_LO 13
`define OHC_PIN_W 15

// Serial bit counts
`define OHC_BIT_LAST 4'h7
`define OHC_BIT_ACK 4'h8
`define OHC_BIT_REL 4'h9

// Edge count before the mode register holds the real strap
`define OHC_STRAP_SETTLE 2'h3

// Upper six bits of the two-wire slave address, value arbitrary
`define OHC_I2C_ADDR_HI 6'h2A

// Buffered word: data, column, row
`define OHC_PIX_W 21

`endif

// *** rtl/ohc_pkg.sv ***
package ohc_pkg;

	// Host link selected by the build straps
	typedef enum logic [1:0] {
		OHC_L8080,
		OHC_L6800,
		OHC_LSPI,
		OHC_LI2C
	} ohc_link_t;

	// Command decoder
	typedef enum logic [1:0] {
		OHC_S_OP,
		OHC_S_P1,
		OHC_S_P2
	} ohc_cmd_st_t;

	// Two-wire receiver
	typedef enum logic [1:0] {
		OHC_I_IDLE,
		OHC_I_ADDR,
		OHC_I_CTL,
		OHC_I_PAY
	} ohc_i2c_st_t;

endpackage

// *** tb/ohc_checker.sv ***
`timescale 1ns/1ps
`include "ohc_params.svh"

// Port-level watch on settings, pixel stream and pin quiet periods
module ohc_checker (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic [1:0] link_strap,
	input wire logic hard_reset_n,
	input wire logic cs_n,
	input wire logic dc_sel,
	input wire logic wr_n,
	input wire logic rd_n,
	input wire logic [7:0] data_in,
	input wire logic sda_out,
	input wire logic sda_oe,
	input wire logic [5:0] col_start,
	input wire logic [5:0] col_end,
	input wire logic [6:0] row_start,
	input wire logic [6:0] row_end,
	input wire logic [7:0] contrast,
	input wire logic [7:0] remap,
	input wire logic link_busy,
	input wire logic pixel_valid,
	input wire logic pixel_ready,
	input wire logic [7:0] pixel_data,
	input wire logic [5:0] pixel_col,
	input wire logic [6:0] pixel_row
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);

	////////////////////////////////////////////////////////////////
	// Pins idle long enough for any byte in flight to have landed
	sequence pins_quiet;
		(cs_n && hard_reset_n)[*8];
	endsequence
	sequence hrst_held;
		(!hard_reset_n)[*3];
	endsequence

	////////////////////////////////////////////////////////////////
	chk_rst_vals: assert property ($rose(rst_n) |->
		contrast == 8'h7F && col_start == 6'h00 && col_end == 6'h3F
		&& row_start == 7'h00 && row_end == 7'h7F && remap == 8'h00)
		else $error("settings not at reset values");
	chk_remap_rsvd: assert property ((remap & ~`OHC_REMAP_MASK) == 8'h00)
		else $error("reserved re-map bit set");
	chk_valid_hold: assert property (pixel_valid && !pixel_ready && hard_reset_n |=>
		pixel_valid && $stable(pixel_data) && $stable(pixel_col) && $stable(pixel_row))
		else $error("stalled pixel word changed");
	// A word staged for one cycle is normal; held two means the buffer is full
	chk_busy_full: assert property (link_busy && $past(link_busy) |-> pixel_valid)
		else $error("busy with empty buffer");
	chk_pix_window: assert property (pixel_valid |->
		(remap[0] ? 6'h3F - pixel_col : pixel_col) >= col_start
		&& (remap[0] ? 6'h3F - pixel_col : pixel_col) <= col_end
		&& pixel_row >= row_start && pixel_row <= row_end)
		else $error("pixel address outside window");
	chk_sda_quiet: assert property (!sda_out && (!sda_oe || link_strap == 2'b11))
		else $error("data line pulled outside two-wire mode");
	// Without a strobe nothing may move; catches spurious decode
	chk_set_stable: assert property (pins_quiet |=> $stable(contrast) && $stable(remap)
		&& $stable({col_start, col_end, row_start, row_end}))
		else $error("setting changed with pins idle");
	chk_hrst_restore: assert property (hrst_held |-> ##[0:3]
		(contrast == 8'h7F && remap == 8'h00 && col_end == 6'h3F && !pixel_valid))
		else $error("hard reset did not restore settings");
endmodule // ohc_checker

// *** tb/ohc_host_model.sv ***
`timescale 1ns/1ps

// Host controller on the 8080 parallel and serial links; writes only
module ohc_host_model (
	input wire logic clk_sys,
	output logic cs_n,
	output logic dc_sel,
	output logic wr_n,
	output logic rd_n,
	output logic [7:0] data_in,
	output logic hard_reset_n
);
	// Idle levels; read strobe held high, driven low only by the serial task
	initial begin
		cs_n = 1'b1;
		dc_sel = 1'b0;
		wr_n = 1'b1;
		rd_n = 1'b1;
		data_in = 8'h00;
		hard_reset_n = 1'b1;
	end

	////////////////////////////////////////////////////////////////
	// One byte; lines scrambled once the strobe has risen
	task automatic wr(input logic dc, input logic [7:0] b);
		@(posedge clk_sys);
		#1;
		cs_n = 1'b0;
		dc_sel = dc;
		data_in = b;
		wr_n = 1'b0;
		repeat (2) @(posedge clk_sys);
		#1;
		wr_n = 1'b1;
		@(posedge clk_sys);
		#1;
		data_in = ~b;
		dc_sel = ~dc;
		repeat (4) @(posedge clk_sys);
		#1;
		cs_n = 1'b1;
	endtask

	// One byte on the serial link, MSB first; clock idles low, four clocks a bit.
	// Select drops four clocks after the last rise so the word is queued in time
	task automatic spi(input logic dc, input logic [7:0] b);
		@(posedge clk_sys);
		#1;
		cs_n = 1'b0;
		wr_n = 1'b0;
		rd_n = 1'b0;
		dc_sel = dc;
		for (int i = 7; i >= 0; i--) begin
			data_in = {6'h00, b[i], 1'b0};
			repeat (2) @(posedge clk_sys);
			#1;
			data_in[0] = 1'b1;
			repeat (2) @(posedge clk_sys);
			#1;
		end
		data_in = 8'h00;
		repeat (2) @(posedge clk_sys);
		#1;
		cs_n = 1'b1;
	endtask

	// Reset pin pulse, longer than the synchroniser
	task automatic hrst;
		@(posedge clk_sys);
		#1;
		hard_reset_n = 1'b0;
		repeat (4) @(posedge clk_sys);
		#1;
		hard_reset_n = 1'b1;
		repeat (4) @(posedge clk_sys);
	endtask
endmodule // ohc_host_model

// *** tb/test_oled_host_command_port.sv ***
`timescale 1ns/1ps

`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin errors++; \
	$display("mismatch at %0t ns: got %h expected %h", $time, got, exp); end end

module test_oled_host_command_port;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic pixel_ready = 1'b0;
	logic stall = 1'b0;
	logic [1:0] strap = 2'b00;
	logic cs_n, dc_sel, wr_n, rd_n, hard_reset_n, sda_out, sda_oe, link_busy, pixel_valid;
	logic [7:0] data_in, contrast, remap, pixel_data, r;
	logic [5:0] col_start, col_end, pixel_col;
	logic [6:0] row_start, row_end, pixel_row;
	int errors = 0;
	int n_checks = 0;
	// Reference state
	logic [5:0] m_cs, m_ce, pc, t6;
	logic [6:0] m_rs, m_re, pr, t7;
	logic [7:0] m_con, m_rm, op;
	logic [20:0] exp_w;
	int st;
	logic [20:0] q[$];

	always #50 clk_sys = ~clk_sys;

	ohc_host_model host (.clk_sys(clk_sys), .cs_n(cs_n), .dc_sel(dc_sel), .wr_n(wr_n),
		.rd_n(rd_n), .data_in(data_in), .hard_reset_n(hard_reset_n));
	ohc_cmd_port uut (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(1'b1), .link_strap(strap),
		.hard_reset_n(hard_reset_n), .cs_n(cs_n), .dc_sel(dc_sel), .wr_n(wr_n), .rd_n(rd_n),
		.data_in(data_in), .sda_out(sda_out), .sda_oe(sda_oe), .col_start(col_start),
		.col_end(col_end), .row_start(row_start), .row_end(row_end), .contrast(contrast),
		.remap(remap), .link_busy(link_busy), .pixel_valid(pixel_valid),
		.pixel_ready(pixel_ready), .pixel_data(pixel_data), .pixel_col(pixel_col),
		.pixel_row(pixel_row));

	////////////////////////////////////////////////////////////////
	task automatic give_verdict;
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	function automatic void m_reset;
		m_cs = 6'h00;
		m_ce = 6'h3F;
		m_rs = 7'h00;
		m_re = 7'h7F;
		m_con = 8'h7F;
		m_rm = 8'h00;
		pc = 6'h00;
		pr = 7'h00;
		st = 0;
	endfunction

	task automatic check_cfg;
		`CHK({col_start, col_end}, {m_cs, m_ce})
		`CHK({row_start, row_end}, {m_rs, m_re})
		`CHK(contrast, m_con)
		`CHK(remap, m_rm)
	endtask

	// Reference for one byte; a data byte drops any half-sent command
	task automatic feed(input logic dc, input logic [7:0] b);
		if (dc) begin
			st = 0;
			if (q.size() < 3) begin
				q.push_back({m_rm[1] ? {b[3:0], b[7:4]} : b, m_rm[0] ? 6'h3F - pc : pc, pr});
				if (!m_rm[2]) begin
					if (pc != m_ce) pc++;
					else begin pc = m_cs; pr = (pr == m_re) ? m_rs : pr + 7'd1; end
				end else begin
					if (pr != m_re) pr++;
					else begin pr = m_rs; pc = (pc == m_ce) ? m_cs : pc + 6'd1; end
				end
			end
		end else if (st == 0) begin
			op = b;
			if (b == 8'h15 || b == 8'h75 || b == 8'h81 || b == 8'hA0) st = 1;
		end else if (st == 1) begin
			case (op)
				8'h15: t6 = b[5:0];
				8'h75: t7 = b[6:0];
				8'h81: m_con = b;
				default: m_rm = b & 8'h57;
			endcase
			st = (op == 8'h15 || op == 8'h75) ? 2 : 0;
		end else begin
			// Window and its pointer axis move only once the end byte lands
			if (op == 8'h15) begin m_cs = t6; m_ce = b[5:0]; pc = m_cs; end
			else begin m_rs = t7; m_re = b[6:0]; pr = m_rs; end
			st = 0;
		end
	endtask

	task automatic send(input logic dc, input logic [7:0] b);
		if (strap == 2'b10) host.spi(dc, b);
		else host.wr(dc, b);
		feed(dc, b);
		if (!dc) check_cfg;
	endtask

	task automatic drain;
		stall = 1'b0;
		for (int i = 0; i < 300 && q.size() > 0; i++) @(posedge clk_sys);
		repeat (4) @(posedge clk_sys);
		`CHK(pixel_valid, 1'b0)
	endtask

	task automatic do_reset;
		@(posedge clk_sys);
		#1;
		rst_n = 1'b0;
		repeat (6) @(posedge clk_sys);
		#1;
		rst_n = 1'b1;
		m_reset();
		q.delete();
		repeat (2) @(posedge clk_sys);
	endtask

	////////////////////////////////////////////////////////////////
	// Consumer; mostly ready so the buffer only fills when stalled
	always @(posedge clk_sys) begin
		if (rst_n && pixel_valid && pixel_ready) begin
			`CHK(q.size() > 0, 1'b1)
			if (q.size() > 0) begin
				exp_w = q.pop_front();
				`CHK({pixel_data, pixel_col, pixel_row}, exp_w)
			end
		end
		#1 pixel_ready = !stall && ($urandom % 4 != 0);
	end

	// Hang guard, several times the expected run
	initial begin
		repeat (20000) @(posedge clk_sys);
		errors++;
		give_verdict();
	end

	initial begin
		void'($urandom(32'h6e6390c8));
		do_reset();
		check_cfg();
		for (int it = 0; it < 8; it++) begin
			r = 8'($urandom % 60);
			send(0, 8'h15);
			send(0, {2'($urandom), r[5:0]});
			send(0, {2'($urandom), r[5:0] + 6'($urandom % 4)});
			r = 8'($urandom % 120);
			send(0, 8'h75);
			send(0, {1'($urandom), r[6:0]});
			send(0, {1'($urandom), r[6:0] + 7'($urandom % 4)});
			send(0, 8'h81);
			send(0, 8'($urandom));
			send(0, 8'hA0);
			send(0, it == 0 ? 8'hFF : 8'($urandom));
			repeat (4 + $urandom % 20) send(1, 8'($urandom));
			drain();
		end
		for (int o = 8'h84; o <= 8'h86; o++) send(0, 8'(o));
		// Half a window command cut short by data
		send(0, 8'h15);
		send(0, 8'h05);
		send(1, 8'hAA);
		send(0, 8'h81);
		send(0, 8'h33);
		drain();
		// Stalled receiver: the fourth word must be refused
		stall = 1'b1;
		repeat (5) begin
			send(1, 8'($urandom));
			`CHK(link_busy, 1'(q.size() >= 3))
		end
		drain();
		// Reset pin in mid-command
		send(0, 8'h81);
		host.hrst();
		m_reset();
		send(0, 8'h40);
		send(0, 8'h81);
		send(0, 8'h12);
		// Serial strap, taken by a second reset in mid-run
		strap = 2'b10;
		do_reset();
		check_cfg();
		send(0, 8'h81);
		send(0, 8'($urandom));
		repeat (3) send(1, 8'($urandom));
		drain();
		give_verdict();
	end
endmodule // test_oled_host_command_port

bind ohc_cmd_port ohc_checker chk_i (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en),
	.link_strap(link_strap), .hard_reset_n(hard_reset_n), .cs_n(cs_n), .dc_sel(dc_sel),
	.wr_n(wr_n), .rd_n(rd_n), .data_in(data_in), .sda_out(sda_out), .sda_oe(sda_oe),
	.col_start(col_start), .col_end(col_end), .row_start(row_start), .row_end(row_end),
	.contrast(contrast), .remap(remap), .link_busy(link_busy), .pixel_valid(pixel_valid),
	.pixel_ready(pixel_ready), .pixel_data(pixel_data), .pixel_col(pixel_col),
	.pixel_row(pixel_row));
